// *** hw/cssu_fosc.sv ***
// oscillator tick and quarter clock generator
// assumes osc_in_pin synchronous to hclk
`timescale 1ns/1ns
`include "cssu_params.svh"
module cssu_fosc (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic osc_in_pin,
	cssu_if.fosc bus
);
	logic in_prev;
	logic next_in_prev;
	logic [4:0] div;
	logic [4:0] next_div;
	logic post;
	logic next_post;
	logic [1:0] quarter;
	logic [1:0] next_quarter;
	logic tick;
	logic next_tick;
	always_comb begin
		next_in_prev = osc_in_pin;
		next_div = div;
		next_post = post;
		next_tick = 1'b0;
		next_quarter = quarter;
		if (!bus.osc_en) begin
			next_div = 5'h00;
		end else if (bus.on_chip) begin
			if (div == 5'(`CSSU_ONCHIP_CYC - 1)) begin
				next_div = 5'h00;
				next_post = ~post;
				// R2 8 MHz or postscaled 4 MHz
				next_tick = bus.freq_choice | post;
			end else begin
				next_div = div + 5'h01;
			end
		end else begin
			next_tick = osc_in_pin & ~in_prev;
		end
		// R11 R13 divide by four
		if (tick) begin
			next_quarter = quarter + 2'h1;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_prev <= 1'b0;
			div <= 5'h00;
			post <= 1'b0;
			tick <= 1'b0;
			quarter <= 2'h0;
		end else begin
			in_prev <= next_in_prev;
			div <= next_div;
			post <= next_post;
			tick <= next_tick;
			quarter <= next_quarter;
		end
	end
	assign bus.fosc_tick = tick;
	assign bus.quarter_clk = quarter[1];
endmodule // cssu_fosc

// *** hw/cssu_ost.sv ***
// start-up counter of oscillator ticks
// assumes cnt_start is a one-cycle pulse
`timescale 1ns/1ns
`include "cssu_params.svh"
module cssu_startup_counter (
	input wire logic hclk,
	input wire logic hresetn,
	cssu_if.startup bus
);
	logic [10:0] count;
	logic [10:0] next_count;
	logic busy;
	logic next_busy;
	always_comb begin
		next_count = count;
		next_busy = busy;
		if (bus.cnt_start) begin
			next_count = 11'h000;
			next_busy = 1'b1;
		end else if (busy && bus.fosc_tick) begin
			// R7 count 1024 oscillations
			next_count = count + 11'h001;
			if (next_count == `CSSU_STARTUP_COUNT) begin
				next_busy = 1'b0;
			end
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 11'h000;
			busy <= 1'b0;
		end else begin
			count <= next_count;
			busy <= next_busy;
		end
	end
	assign bus.cnt_busy = busy;
	assign bus.cnt_value = count;
endmodule // cssu_startup_counter

// *** hw/cssu_top.sv ***
// clock source select and start-up sequencer, AHB-Lite slave
// assumes straps stable at reset release, pins synchronous to hclk
// Overview of operation
// R1 - eight clock source modes chosen by a three-bit mode strap
// R2 - on-chip modes give a 4 MHz postscaled or 8 MHz system clock
// R3 - one strap bit picks 4 MHz or 8 MHz on-chip clock
// R4 - driven mode takes clock on osc_in_pin, frees osc_out_pin as gpio
// R5 - driven mode skips the start-up counter entirely
// R6 - stopped driven clock halts execution, state kept, resumes in place
// R7 - crystal modes count 1024 oscillations before clock is stable
// R8 - count starts after power-up delay if enabled, and on every wake
// R9 - program counter held and execution suspended while counting
// R10 - crystal modes set amplifier gain low, medium, high
// R11 - res_cap_divout_mode drives osc_out_pin with fosc divided by four
// R12 - res_cap_pin_mode frees osc_out_pin as gpio
// R13 - on-chip divout mode outputs fosc/4, frees osc_in_pin as gpio
// R14 - on-chip pin mode frees both oscillator pins as gpio
// R15 - mode straps sampled only at reset, fixed afterwards
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "cssu_params.svh"
module cssu_top #(
	parameter int POWER_DELAY_CYCLES = `CSSU_POWER_DELAY_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [2:0] clk_mode_cfg,
	input wire logic on_chip_freq_choice,
	input wire logic power_up_delay_en,
	input wire logic wake_evt,
	input wire logic osc_in_pin,
	output logic osc_in_o,
	output logic osc_in_oe,
	output logic osc_out_o,
	output logic osc_out_oe,
	input wire logic gpio_in_o,
	input wire logic gpio_in_oe,
	input wire logic gpio_out_o,
	input wire logic gpio_out_oe,
	output logic [1:0] amp_gain,
	output logic exec_tick,
	output logic pc_hold
);
	cssu_if link ();
	cssu_fosc u_fosc (
		.hclk(hclk),
		.hresetn(hresetn),
		.osc_in_pin(osc_in_pin),
		.bus(link)
	);
	cssu_startup_counter u_startup (
		.hclk(hclk),
		.hresetn(hresetn),
		.bus(link)
	);

	// configuration and sequencing state
	cssu_pkg::cssu_mode_t mode;
	cssu_pkg::cssu_mode_t next_mode;
	logic freq;
	logic next_freq;
	logic delay_en;
	logic next_delay_en;
	cssu_pkg::cssu_state_t state;
	cssu_pkg::cssu_state_t next_state;
	logic [31:0] delay;
	logic [31:0] next_delay;
	logic start;
	logic next_start;
	logic sleep_req;
	logic wake_req;
	logic crystal;
	logic running;

	always_comb begin
		crystal = (mode == cssu_pkg::low_gain_crystal_mode) || (mode == cssu_pkg::mid_gain_crystal_mode)
			|| (mode == cssu_pkg::high_gain_crystal_mode);
		next_mode = mode;
		next_freq = freq;
		next_delay_en = delay_en;
		next_state = state;
		next_delay = delay;
		next_start = 1'b0;
		case (state)
			cssu_pkg::st_capture: begin
				// R15 straps taken once
				next_mode = cssu_pkg::cssu_mode_t'(clk_mode_cfg);
				// R3 frequency strap
				next_freq = on_chip_freq_choice;
				next_delay_en = power_up_delay_en;
				next_delay = 32'h0000_0000;
				next_state = cssu_pkg::st_power_delay;
			end
			cssu_pkg::st_power_delay: begin
				// R8 wait for power-up delay
				if (delay_en && (delay != 32'(POWER_DELAY_CYCLES - 1))) begin
					next_delay = delay + 32'h0000_0001;
				end else if (crystal) begin
					next_start = 1'b1;
					next_state = cssu_pkg::st_counting;
				end else begin
					// R5 no start-up count
					next_state = cssu_pkg::st_running;
				end
			end
			cssu_pkg::st_counting: begin
				// R9 hold until count completes
				if (!start && !link.cnt_busy) begin
					next_state = cssu_pkg::st_running;
				end
			end
			cssu_pkg::st_running: begin
				if (sleep_req) begin
					next_state = cssu_pkg::st_sleeping;
				end
			end
			cssu_pkg::st_sleeping: begin
				if (wake_evt || wake_req) begin
					// R8 count again on wake
					if (crystal) begin
						next_start = 1'b1;
						next_state = cssu_pkg::st_counting;
					end else begin
						next_state = cssu_pkg::st_running;
					end
				end
			end
			default: next_state = cssu_pkg::st_capture;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= cssu_pkg::driven_clk_in_mode;
			freq <= 1'b0;
			delay_en <= 1'b0;
			state <= cssu_pkg::st_capture;
			delay <= 32'h0000_0000;
			start <= 1'b0;
		end else begin
			mode <= next_mode;
			freq <= next_freq;
			delay_en <= next_delay_en;
			state <= next_state;
			delay <= next_delay;
			start <= next_start;
		end
	end

	assign link.osc_en = (state != cssu_pkg::st_sleeping) && (state != cssu_pkg::st_capture);
	// R2 on-chip source select
	assign link.on_chip = (mode == cssu_pkg::on_chip_osc_divout_mode) || (mode == cssu_pkg::on_chip_osc_pin_mode);
	assign link.freq_choice = freq;
	assign link.cnt_start = start;
	assign running = (state == cssu_pkg::st_running);

	// pin functions and core outputs
	logic next_osc_in_o;
	logic next_osc_in_oe;
	logic next_osc_out_o;
	logic next_osc_out_oe;
	logic [1:0] next_amp_gain;
	logic next_exec_tick;
	logic next_pc_hold;

	always_comb begin
		next_osc_in_o = 1'b0;
		next_osc_in_oe = 1'b0;
		next_osc_out_o = 1'b0;
		next_osc_out_oe = 1'b0;
		next_amp_gain = 2'h0;
		// R1 eight mode decode
		case (mode)
			cssu_pkg::driven_clk_in_mode, cssu_pkg::res_cap_pin_mode: begin
				// R4 R12 osc_out_pin released
				next_osc_out_o = gpio_out_o;
				next_osc_out_oe = gpio_out_oe;
			end
			cssu_pkg::low_gain_crystal_mode: begin
				// R10 gain low
				next_amp_gain = 2'h1;
			end
			cssu_pkg::mid_gain_crystal_mode: begin
				// R10 gain medium
				next_amp_gain = 2'h2;
			end
			cssu_pkg::high_gain_crystal_mode: begin
				// R10 gain high
				next_amp_gain = 2'h3;
			end
			cssu_pkg::res_cap_divout_mode: begin
				// R11 quarter clock out
				next_osc_out_o = link.quarter_clk;
				next_osc_out_oe = 1'b1;
			end
			cssu_pkg::on_chip_osc_divout_mode: begin
				// R13 quarter clock, osc_in_pin free
				next_osc_out_o = link.quarter_clk;
				next_osc_out_oe = 1'b1;
				next_osc_in_o = gpio_in_o;
				next_osc_in_oe = gpio_in_oe;
			end
			default: begin
				// R14 both pins free
				next_osc_in_o = gpio_in_o;
				next_osc_in_oe = gpio_in_oe;
				next_osc_out_o = gpio_out_o;
				next_osc_out_oe = gpio_out_oe;
			end
		endcase
		// R6 R9 ticks only while running
		next_exec_tick = running && link.fosc_tick;
		next_pc_hold = !running;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc_in_o <= 1'b0;
			osc_in_oe <= 1'b0;
			osc_out_o <= 1'b0;
			osc_out_oe <= 1'b0;
			amp_gain <= 2'h0;
			exec_tick <= 1'b0;
			pc_hold <= 1'b1;
		end else begin
			osc_in_o <= next_osc_in_o;
			osc_in_oe <= next_osc_in_oe;
			osc_out_o <= next_osc_out_o;
			osc_out_oe <= next_osc_out_oe;
			amp_gain <= next_amp_gain;
			exec_tick <= next_exec_tick;
			pc_hold <= next_pc_hold;
		end
	end

	// AHB-Lite slave, zero wait states
	logic wr_pend;
	logic next_wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic [31:0] status;
	logic take;

	always_comb begin
		take = hsel && hready && htrans[1];
		status = 32'h0000_0000;
		status[2:0] = mode;
		status[`CSSU_ST_FREQ] = freq;
		status[`CSSU_ST_DELAY_EN] = delay_en;
		status[`CSSU_ST_RUN] = running;
		status[`CSSU_ST_COUNTING] = (state == cssu_pkg::st_counting);
		status[`CSSU_ST_SLEEP] = (state == cssu_pkg::st_sleeping);
		status[`CSSU_ST_DELAY] = (state == cssu_pkg::st_power_delay);
		next_wr_pend = take && hwrite;
		next_wr_addr = haddr[7:0];
		next_hrdata = 32'h0000_0000;
		if (take && !hwrite) begin
			if (haddr[7:0] == `CSSU_ADDR_STATUS) begin
				next_hrdata = status;
			end else if (haddr[7:0] == `CSSU_ADDR_COUNT) begin
				next_hrdata = {21'h0, link.cnt_value};
			end else begin
				next_hrdata = 32'h0000_0000;
			end
		end
		sleep_req = wr_pend && (wr_addr == `CSSU_ADDR_CTRL) && hwdata[`CSSU_CTRL_SLEEP];
		wake_req = wr_pend && (wr_addr == `CSSU_ADDR_CTRL) && hwdata[`CSSU_CTRL_WAKE];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule // cssu_top

// *** include/cssu_if.sv ***
// signals shared between the top and its two helpers
// assumes one hclk domain
`timescale 1ns/1ns
interface cssu_if;
	logic osc_en;
	logic on_chip;
	logic freq_choice;
	logic fosc_tick;
	logic quarter_clk;
	logic cnt_start;
	logic cnt_busy;
	logic [10:0] cnt_value;
	modport top (output osc_en, on_chip, freq_choice, cnt_start, input fosc_tick, quarter_clk, cnt_busy, cnt_value);
	modport fosc (input osc_en, on_chip, freq_choice, output fosc_tick, quarter_clk);
	modport startup (input fosc_tick, cnt_start, output cnt_busy, cnt_value);
endinterface

// *** include/cssu_params.svh ***
// constants for the clock source select and start-up block
// assumes a 100 MHz hclk and AHB-Lite register access
`ifndef CSSU_PARAMS_SVH
`define CSSU_PARAMS_SVH
`define CSSU_HCLK_HZ 100000000
`define CSSU_ONCHIP_HZ 8000000
`define CSSU_ONCHIP_CYC (`CSSU_HCLK_HZ / `CSSU_ONCHIP_HZ)
`define CSSU_STARTUP_COUNT 11'h400
`define CSSU_POWER_DELAY_US 64000
`define CSSU_POWER_DELAY_CYC ((`CSSU_POWER_DELAY_US) * (`CSSU_HCLK_HZ / 1000000))
`define CSSU_ADDR_STATUS 8'h00
`define CSSU_ADDR_CTRL 8'h04
`define CSSU_ADDR_COUNT 8'h08
`define CSSU_CTRL_SLEEP 0
`define CSSU_CTRL_WAKE 1
`define CSSU_ST_FREQ 3
`define CSSU_ST_DELAY_EN 4
`define CSSU_ST_RUN 8
`define CSSU_ST_COUNTING 9
`define CSSU_ST_SLEEP 10
`define CSSU_ST_DELAY 11
`endif

// *** include/cssu_pkg.sv ***
// types for the clock source select and start-up block
// assumes nothing beyond the params header
package cssu_pkg;
	typedef enum logic [2:0] {
		driven_clk_in_mode,
		low_gain_crystal_mode,
		mid_gain_crystal_mode,
		high_gain_crystal_mode,
		res_cap_divout_mode,
		res_cap_pin_mode,
		on_chip_osc_divout_mode,
		on_chip_osc_pin_mode
	} cssu_mode_t;
	typedef enum logic [2:0] {
		st_capture,
		st_power_delay,
		st_counting,
		st_running,
		st_sleeping
	} cssu_state_t;
endpackage

// *** tb/cssu_checker.sv ***
// port assertions for the clock select block
// assumes bind onto cssu_top, one hclk domain
`timescale 1ns/1ns
module cssu_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [2:0] clk_mode_cfg,
	input wire logic power_up_delay_en,
	input wire logic osc_in_pin,
	input wire logic osc_in_oe,
	input wire logic osc_out_oe,
	input wire logic gpio_in_oe,
	input wire logic gpio_out_oe,
	input wire logic [1:0] amp_gain,
	input wire logic exec_tick,
	input wire logic pc_hold
);
	logic [1:0] up;
	logic [2:0] m;
	logic [10:0] n;
	logic done;
	logic prev;
	logic crystal_m;
	assign crystal_m = m != 3'h0 && m < 3'h4;
	// captured mode and first-start edge count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up <= 2'h0;
			m <= 3'h0;
			n <= 11'h0;
			done <= 1'b0;
			prev <= 1'b0;
		end else begin
			up <= {up[0], 1'b1};
			prev <= osc_in_pin;
			if (!up[0]) m <= clk_mode_cfg;
			if (!pc_hold) done <= 1'b1;
			if (osc_in_pin && !prev && !done) n <= n + 11'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_quiet;
		(up[1] && m == 3'h0 && !osc_in_pin) [*4];
	endsequence
	sequence s_start;
		$rose(up[1]) && m == 3'h0 && !power_up_delay_en;
	endsequence
	property p_hold; pc_hold |-> !exec_tick; endproperty
	a_hold: assert property (p_hold) else $error("exec tick while held");
	property p_gain; up[1] |-> amp_gain == (crystal_m ? m[1:0] : 2'h0); endproperty
	a_gain: assert property (p_gain) else $error("wrong gain");
	property p_in_free; up[1] && m[2:1] == 2'h3 |-> osc_in_oe == $past(gpio_in_oe); endproperty
	a_in_free: assert property (p_in_free) else $error("input pin not released");
	property p_in_kept; up[1] && m[2:1] != 2'h3 |-> !osc_in_oe; endproperty
	a_in_kept: assert property (p_in_kept) else $error("input pin driven");
	property p_out_free; up[1] && (m == 3'h0 || m == 3'h5 || m == 3'h7) |-> osc_out_oe == $past(gpio_out_oe);
	endproperty
	a_out_free: assert property (p_out_free) else $error("output pin not released");
	property p_out_div; up[1] && (m == 3'h4 || m == 3'h6) |-> osc_out_oe; endproperty
	a_out_div: assert property (p_out_div) else $error("quarter clock not driven");
	property p_startup; up[1] && crystal_m && !power_up_delay_en && !done && $fell(pc_hold)
		|-> n >= 11'h400 && n <= 11'h402;
	endproperty
	a_startup: assert property (p_startup) else $error("start-up count wrong");
	property p_stop; s_quiet |-> !exec_tick; endproperty
	a_stop: assert property (p_stop) else $error("tick without clock");
	property p_fast; s_start |-> ##[1:4] !pc_hold; endproperty
	a_fast: assert property (p_fast) else $error("driven mode delayed");
endmodule // cssu_checker

bind cssu_top cssu_checker u_cssu_checker (.hclk, .hresetn, .clk_mode_cfg, .power_up_delay_en, .osc_in_pin,
	.osc_in_oe, .osc_out_oe, .gpio_in_oe, .gpio_out_oe, .amp_gain, .exec_tick, .pc_hold);

// *** tb/cssu_osc_model.sv ***
// oscillator source driving osc_in_pin
// assumes edges synchronous to hclk
`timescale 1ns/1ns
module cssu_osc_model (
	input wire logic hclk,
	input wire logic run,
	input wire logic [7:0] half,
	output logic osc
);
	logic [7:0] cnt;
	initial begin
		osc = 1'b0;
		cnt = 8'h0;
	end
	// logic-level clock, rests low when stopped
	always @(posedge hclk) begin
		if (!run) begin
			osc <= 1'b0;
			cnt <= 8'h0;
		end else if (cnt + 8'h1 >= half) begin
			osc <= !osc;
			cnt <= 8'h0;
		end else begin
			cnt <= cnt + 8'h1;
		end
	end
endmodule // cssu_osc_model

// *** tb/cssu_top_test.sv ***
// self-checking bench for the clock select block
// assumes a 20-cycle power-up delay
`timescale 1ns/1ns
`include "cssu_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module cssu_top_test;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, qprev;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, amp_gain;
	logic [2:0] clk_mode_cfg;
	logic on_chip_freq_choice, power_up_delay_en, wake_evt, osc_in_pin, osc_in_o, osc_in_oe, osc_out_o, osc_out_oe;
	logic gpio_in_o, gpio_in_oe, gpio_out_o, gpio_out_oe, exec_tick, pc_hold;
	logic [7:0] half;
	int failures, checks_done, ticks, gap, last, qgap, qlast, cyc, e, t0;
	cssu_top #(.POWER_DELAY_CYCLES(20)) u_cssu_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .clk_mode_cfg, .on_chip_freq_choice,
		.power_up_delay_en, .wake_evt, .osc_in_pin, .osc_in_o, .osc_in_oe, .osc_out_o, .osc_out_oe,
		.gpio_in_o, .gpio_in_oe, .gpio_out_o, .gpio_out_oe, .amp_gain, .exec_tick, .pc_hold);
	cssu_osc_model u_cssu_osc_model (.hclk, .run, .half, .osc(osc_in_pin));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (exec_tick === 1'b1) begin
			ticks++;
			gap = cyc - last;
			last = cyc;
		end
		if (osc_out_o === 1'b1 && qprev !== 1'b1) begin
			qgap = cyc - qlast;
			qlast = cyc;
		end
		qprev = osc_out_o;
	end
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic start(input logic [2:0] m, input logic p);
		@(posedge hclk);
		hresetn <= 1'b0;
		clk_mode_cfg <= m;
		on_chip_freq_choice <= m[0];
		power_up_delay_en <= p;
		gpio_in_o <= m[0];
		gpio_out_o <= m[1];
		gpio_in_oe <= m[0];
		gpio_out_oe <= ~m[0];
		half <= {7'h0, m[0]} + 8'h2;
		run <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK(pc_hold, 1'b1)
		hresetn <= 1'b1;
		gap = 0;
		qgap = 0;
	endtask
	task automatic wait_run();
		for (int i = 0; i < 9000 && pc_hold !== 1'b0; i++) @(posedge hclk);
		`CHK(pc_hold, 1'b0)
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge hclk);
		failures++;
		stop_test();
	end
	initial begin
		{hresetn, hsel, hwrite, run, wake_evt, on_chip_freq_choice, power_up_delay_en} = 7'h0;
		{haddr, hwdata, htrans, clk_mode_cfg, half} = 0;
		{gpio_in_o, gpio_in_oe, gpio_out_o, gpio_out_oe} = 4'h5;
		for (int m = 0; m < 8; m++) begin
			start(m[2:0], 1'b0);
			xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
			clk_mode_cfg <= ~m[2:0];
			wait_run();
			xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
			`CHK(rd[11:0], {8'h10, m[0], m[2:0]})
			`CHK(osc_in_o, m == 7)
			if (m != 4 && m != 6) `CHK(osc_out_o, m == 7)
			e = m > 5 ? `CSSU_ONCHIP_CYC * (2 - m % 2) : 4 + 2 * (m % 2);
			repeat (250) @(posedge hclk);
			`CHK(gap, e)
			if (m == 4 || m == 6) `CHK(qgap, 4 * e)
			if (m == 0) begin
				run <= 1'b0;
				repeat (10) @(posedge hclk);
				t0 = ticks;
				repeat (20) @(posedge hclk);
				`CHK(ticks, t0)
				xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
				`CHK(rd[8], 1'b1)
				run <= 1'b1;
				repeat (20) @(posedge hclk);
				`CHK(ticks > t0, 1'b1)
			end
			xfer(1'b1, `CSSU_ADDR_CTRL, 32'h1);
			repeat (2) @(posedge hclk);
			t0 = ticks;
			repeat (30) @(posedge hclk);
			`CHK(ticks, t0)
			if (m % 2 == 1) begin
				wake_evt <= 1'b1;
				@(posedge hclk);
				wake_evt <= 1'b0;
			end else xfer(1'b1, `CSSU_ADDR_CTRL, 32'h2);
			xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
			`CHK(rd[9], m > 0 && m < 4)
			wait_run();
		end
		start(3'h1, 1'b1);
		xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
		`CHK(rd[11:8], 4'h8)
		repeat (25) @(posedge hclk);
		xfer(1'b0, `CSSU_ADDR_STATUS, 32'h0);
		`CHK(rd[11:8], 4'h2)
		xfer(1'b0, 32'hc, 32'h0);
		`CHK(rd, 32'h0) // unmapped
		`CHK(hresp, 1'b0) // okay
		wait_run();
		stop_test();
	end
endmodule // cssu_top_test
